// file: rtl/utsris_pkg.sv
// package: register map, field layout, reset values and states of the transmit control block
//
// Overview of operation
// - with transmit interrupt select 10 the transmit interrupt fires when a character moves to the shifter and leaves the buffer empty.
// - with transmit interrupt select 01 the transmit interrupt fires once the last character has fully left the shifter.
// - with transmit interrupt select 00 the transmit interrupt fires every time a character moves to the shifter.
// - with infrared encoding off, polarity invert set idles the line low and cleared idles it high.
// - with infrared encoding on, polarity invert set idles the encoded line high and cleared idles it low.
// - with transmit enable set the block drives the transmit pin instead of the port logic.
// - clearing transmit enable aborts any transmission, empties the buffer and hands the pin back to the port logic.
// - the shift empty flag is 1 only when shifter and buffer are both empty, else 0.
// - with receive interrupt select 11 the receive interrupt fires when a transfer leaves four characters in the buffer.
// - with receive interrupt select 10 the receive interrupt fires when a transfer leaves three characters in the buffer.
// - with receive interrupt select 0x the receive interrupt fires on every transfer into the buffer.
package utsris_pkg;

  // ==========================================================================
  // bus and register map
  localparam int          WB_ADR_W       = 4;
  localparam int          WB_DAT_W       = 32;
  localparam int          WB_SEL_W       = 4;
  localparam logic [3:0]  OFS_STATUS_CTRL = 4'h0;
  localparam logic [3:0]  OFS_TX_DATA     = 4'h4;
  localparam logic [3:0]  OFS_AUX_CTRL    = 4'h8;

  // ==========================================================================
  // status and control field positions
  localparam int BIT_TX_SEL_HI    = 15;
  localparam int BIT_TX_INVERT    = 14;
  localparam int BIT_TX_SEL_LO    = 13;
  localparam int BIT_TX_BREAK     = 11;
  localparam int BIT_TX_ENABLE    = 10;
  localparam int BIT_TX_FULL      = 9;
  localparam int BIT_TX_SHIFT_MT  = 8;
  localparam int BIT_RX_SEL_HI    = 7;
  localparam int BIT_RX_SEL_LO    = 6;
  localparam int BIT_IR_ENABLE    = 0;

  // ==========================================================================
  // reset values
  localparam logic [1:0] RST_TX_SEL    = 2'h0;
  localparam logic       RST_TX_INVERT = 1'h0;
  localparam logic       RST_TX_BREAK  = 1'h0;
  localparam logic       RST_TX_ENABLE = 1'h0;
  localparam logic [1:0] RST_RX_SEL    = 2'h0;
  localparam logic       RST_IR_ENABLE = 1'h0;

  // ==========================================================================
  // interrupt mode codes
  localparam logic [1:0] TX_SEL_EACH   = 2'h0;
  localparam logic [1:0] TX_SEL_DONE   = 2'h1;
  localparam logic [1:0] TX_SEL_EMPTY  = 2'h2;
  localparam logic [1:0] RX_SEL_FULL   = 2'h3;
  localparam logic [1:0] RX_SEL_3QTR   = 2'h2;

  // ==========================================================================
  // counts and defaults
  localparam int DEF_CLKS_PER_BIT = 16;
  localparam int DEF_TX_DEPTH     = 4;
  localparam int DEF_RX_DEPTH     = 4;
  localparam int CHAR_BITS        = 8;
  localparam int BREAK_BITS       = 12;

  // ==========================================================================
  // types
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } utsris_wb_req_s;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_FETCH,
    TX_START,
    TX_DATA,
    TX_BREAK,
    TX_STOP
  } utsris_tx_state_e;

endpackage

// file: rtl/utsris_mem.sv
// small buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module utsris_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule
`default_nettype wire

// file: rtl/utsris_top.sv
// transmit control, status and receive interrupt selection with wishbone register access
`timescale 1ns/1ps
`default_nettype none
module utsris_top #(
  parameter int CLKS_PER_BIT = utsris_pkg::DEF_CLKS_PER_BIT,
  parameter int TX_DEPTH     = utsris_pkg::DEF_TX_DEPTH,
  parameter int RX_DEPTH     = utsris_pkg::DEF_RX_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire utsris_pkg::utsris_wb_req_s wb_req_i,
  output logic                            wb_ack_o,
  output logic [utsris_pkg::WB_DAT_W-1:0] wb_dat_o,
  input  wire logic                       rx_push_i,
  input  wire logic [$clog2(RX_DEPTH+1)-1:0] rx_level_i,
  output logic                            tx_pin_o,
  output logic                            tx_pin_oe_o,
  output logic                            tx_irq_o,
  output logic                            rx_irq_o
);

  localparam int PW      = $clog2(TX_DEPTH);
  localparam int CW      = $clog2(TX_DEPTH+1);
  localparam int DW      = $clog2(CLKS_PER_BIT);
  localparam int LW      = $clog2(RX_DEPTH+1);
  localparam int IR_CLKS = CLKS_PER_BIT / 4;

  localparam logic [CW-1:0] TX_FULL_CNT = CW'(TX_DEPTH);
  localparam logic [CW-1:0] TX_ONE_CNT  = CW'(1);
  localparam logic [DW-1:0] DIV_LAST    = DW'(CLKS_PER_BIT - 1);
  localparam logic [DW-1:0] IR_LIMIT    = DW'(IR_CLKS);
  localparam logic [3:0]    DATA_LAST   = 4'(utsris_pkg::CHAR_BITS - 1);
  localparam logic [3:0]    BREAK_LAST  = 4'(utsris_pkg::BREAK_BITS - 1);
  localparam logic [LW-1:0] RX_FULL_LVL = LW'(RX_DEPTH);
  localparam logic [LW-1:0] RX_3QTR_LVL = LW'((RX_DEPTH * 3) / 4);

  // ==========================================================================
  // elaboration checks
  generate
    if (CLKS_PER_BIT < 4) begin : g_bad_div
      $error("clocks per bit must be at least four");
    end
    if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_bad_tx
      $error("transmit depth must be a power of two of at least two");
    end
    if (RX_DEPTH < 4 || (RX_DEPTH % 4) != 0) begin : g_bad_rx
      $error("receive depth must be a multiple of four");
    end
  endgenerate

  // ==========================================================================
  // declarations
  logic [1:0]                   tx_irq_select;
  logic                         tx_polarity_invert;
  logic                         tx_break_request;
  logic                         tx_enable;
  logic [1:0]                   rx_irq_select;
  logic                         infrared_encode_enable;
  logic                         tx_buffer_full;
  logic                         tx_shift_empty;
  logic [PW-1:0]                wr_ptr;
  logic [PW-1:0]                rd_ptr;
  logic [CW-1:0]                tx_count;
  logic [7:0]                   fifo_rd_data;
  logic [7:0]                   shreg;
  logic [DW-1:0]                div_cnt;
  logic [3:0]                   bit_idx;
  logic                         sending_break;
  utsris_pkg::utsris_tx_state_e state;
  utsris_pkg::utsris_tx_state_e next_state;
  logic                         bus_req;
  logic                         wr_stat;
  logic                         wr_data;
  logic                         wr_aux;
  logic                         push;
  logic                         pop;
  logic                         bit_tick;
  logic                         frame_done;
  logic                         raw_line;
  logic                         next_pin;
  logic [15:0]                  stat_word;

  // flag equations
  assign tx_buffer_full = (tx_count == TX_FULL_CNT);
  assign tx_shift_empty = (state == utsris_pkg::TX_IDLE) && (tx_count == '0);

  // ==========================================================================
  // wishbone slave decode, one wait state then ack
  assign bus_req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr_stat = bus_req && wb_req_i.we && (wb_req_i.adr == utsris_pkg::OFS_STATUS_CTRL);
  assign wr_data = bus_req && wb_req_i.we && (wb_req_i.adr == utsris_pkg::OFS_TX_DATA);
  assign wr_aux  = bus_req && wb_req_i.we && (wb_req_i.adr == utsris_pkg::OFS_AUX_CTRL);

  // ack generation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // status word as software sees it
  always_comb begin
    stat_word = 16'h0000;
    stat_word[utsris_pkg::BIT_TX_SEL_HI]   = tx_irq_select[1];
    stat_word[utsris_pkg::BIT_TX_INVERT]   = tx_polarity_invert;
    stat_word[utsris_pkg::BIT_TX_SEL_LO]   = tx_irq_select[0];
    stat_word[utsris_pkg::BIT_TX_BREAK]    = tx_break_request;
    stat_word[utsris_pkg::BIT_TX_ENABLE]   = tx_enable;
    stat_word[utsris_pkg::BIT_TX_FULL]     = tx_buffer_full;
    stat_word[utsris_pkg::BIT_TX_SHIFT_MT] = tx_shift_empty;
    stat_word[utsris_pkg::BIT_RX_SEL_HI]   = rx_irq_select[1];
    stat_word[utsris_pkg::BIT_RX_SEL_LO]   = rx_irq_select[0];
  end

  // read data register, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_req_i.we) begin
      case (wb_req_i.adr)
        utsris_pkg::OFS_STATUS_CTRL: wb_dat_o <= {16'h0000, stat_word};
        utsris_pkg::OFS_TX_DATA:     wb_dat_o <= 32'(tx_count);
        utsris_pkg::OFS_AUX_CTRL:    wb_dat_o <= 32'(infrared_encode_enable);
        default:                     wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================================
  // control fields, lane 1 holds transmit controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_select      <= utsris_pkg::RST_TX_SEL;
      tx_polarity_invert <= utsris_pkg::RST_TX_INVERT;
      tx_enable          <= utsris_pkg::RST_TX_ENABLE;
    end else if (wr_stat && wb_req_i.sel[1]) begin
      tx_irq_select      <= {wb_req_i.dat[utsris_pkg::BIT_TX_SEL_HI],
                             wb_req_i.dat[utsris_pkg::BIT_TX_SEL_LO]};
      tx_polarity_invert <= wb_req_i.dat[utsris_pkg::BIT_TX_INVERT];
      tx_enable          <= wb_req_i.dat[utsris_pkg::BIT_TX_ENABLE];
    end
  end

  // receive select in lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_select <= utsris_pkg::RST_RX_SEL;
    end else if (wr_stat && wb_req_i.sel[0]) begin
      rx_irq_select <= {wb_req_i.dat[utsris_pkg::BIT_RX_SEL_HI],
                        wb_req_i.dat[utsris_pkg::BIT_RX_SEL_LO]};
    end
  end

  // infrared encoder enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      infrared_encode_enable <= utsris_pkg::RST_IR_ENABLE;
    end else if (wr_aux && wb_req_i.sel[0]) begin
      infrared_encode_enable <= wb_req_i.dat[utsris_pkg::BIT_IR_ENABLE];
    end
  end

  // break request: software write of one beats the hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_break_request <= utsris_pkg::RST_TX_BREAK;
    end else if (wr_stat && wb_req_i.sel[1]) begin
      tx_break_request <= wb_req_i.dat[utsris_pkg::BIT_TX_BREAK];
    end else if (frame_done && sending_break) begin
      tx_break_request <= 1'b0;
    end
  end

  // ==========================================================================
  // transmit buffer pointers; writes while full or disabled are dropped
  assign push = wr_data && wb_req_i.sel[0] && tx_enable && !tx_buffer_full;
  assign pop  = (state == utsris_pkg::TX_FETCH);

  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_enable) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      tx_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      if (push && !pop) begin
        tx_count <= tx_count + CW'(1);
      end else if (pop && !push) begin
        tx_count <= tx_count - CW'(1);
      end
    end
  end

  utsris_mem #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_mem (
    .clk_i     (clk_i),
    .wr_en_i   (push),
    .wr_addr_i (wr_ptr),
    .wr_data_i (wb_req_i.dat[7:0]),
    .rd_addr_i (rd_ptr),
    .rd_data_o (fifo_rd_data)
  );

  // ==========================================================================
  // bit rate divider, restarted when a character is loaded
  assign bit_tick   = (div_cnt == DIV_LAST);
  assign frame_done = (state == utsris_pkg::TX_STOP) && bit_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i || state == utsris_pkg::TX_IDLE || state == utsris_pkg::TX_FETCH) begin
      div_cnt <= '0;
    end else if (bit_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DW'(1);
    end
  end

  // next state of the transmit sequencer
  always_comb begin
    next_state = state;
    case (state)
      utsris_pkg::TX_IDLE:  if (tx_count != '0) next_state = utsris_pkg::TX_FETCH;
      utsris_pkg::TX_FETCH: next_state = utsris_pkg::TX_START;
      utsris_pkg::TX_START: begin
        if (bit_tick) begin
          next_state = sending_break ? utsris_pkg::TX_BREAK : utsris_pkg::TX_DATA;
        end
      end
      utsris_pkg::TX_DATA:  if (bit_tick && bit_idx == DATA_LAST) next_state = utsris_pkg::TX_STOP;
      utsris_pkg::TX_BREAK: if (bit_tick && bit_idx == BREAK_LAST) next_state = utsris_pkg::TX_STOP;
      utsris_pkg::TX_STOP:  if (bit_tick) next_state = utsris_pkg::TX_IDLE;
      default:              next_state = utsris_pkg::TX_IDLE;
    endcase
  end

  // sequencer state, aborted by disable
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_enable) begin
      state <= utsris_pkg::TX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // shifter, bit counter and break marker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg         <= 8'h00;
      bit_idx       <= 4'h0;
      sending_break <= 1'b0;
    end else if (state == utsris_pkg::TX_FETCH) begin
      shreg         <= fifo_rd_data;
      bit_idx       <= 4'h0;
      sending_break <= tx_break_request;
    end else if (bit_tick && state == utsris_pkg::TX_DATA) begin
      shreg   <= {1'b0, shreg[7:1]};
      bit_idx <= bit_idx + 4'h1;
    end else if (bit_tick && state == utsris_pkg::TX_BREAK) begin
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // ==========================================================================
  // line level: start and break bits low, idle and stop high
  always_comb begin
    case (state)
      utsris_pkg::TX_START: raw_line = 1'b0;
      utsris_pkg::TX_BREAK: raw_line = 1'b0;
      utsris_pkg::TX_DATA:  raw_line = shreg[0];
      default:              raw_line = 1'b1;
    endcase
    // infrared: pulse in the first quarter of a zero bit, else quiet
    if (infrared_encode_enable) begin
      next_pin = (!raw_line && div_cnt < IR_LIMIT) ^ tx_polarity_invert;
    end else begin
      next_pin = raw_line ^ tx_polarity_invert;
    end
  end

  // pin drive and ownership
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe_o <= 1'b0;
    end else begin
      tx_pin_o    <= next_pin;
      tx_pin_oe_o <= tx_enable;
    end
  end

  // ==========================================================================
  // transmit interrupt pulse by mode; reserved code raises nothing
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_enable) begin
      tx_irq_o <= 1'b0;
    end else begin
      case (tx_irq_select)
        utsris_pkg::TX_SEL_EACH:  tx_irq_o <= pop;
        utsris_pkg::TX_SEL_EMPTY: tx_irq_o <= pop && tx_count == TX_ONE_CNT && !push;
        utsris_pkg::TX_SEL_DONE:  tx_irq_o <= frame_done && tx_count == '0;
        default:                  tx_irq_o <= 1'b0;
      endcase
    end
  end

  // receive interrupt pulse on transfer into the receive buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o <= 1'b0;
    end else begin
      case (rx_irq_select)
        utsris_pkg::RX_SEL_FULL: rx_irq_o <= rx_push_i && rx_level_i == RX_FULL_LVL;
        utsris_pkg::RX_SEL_3QTR: rx_irq_o <= rx_push_i && rx_level_i == RX_3QTR_LVL;
        default:                 rx_irq_o <= rx_push_i;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: tb/utsris_props.sv
// checker: port-level assertions for the transmit control block
`timescale 1ns/1ps
`default_nettype none
module utsris_props #(
  parameter int CLKS_PER_BIT = utsris_pkg::DEF_CLKS_PER_BIT,
  parameter int TX_DEPTH     = utsris_pkg::DEF_TX_DEPTH,
  parameter int RX_DEPTH     = utsris_pkg::DEF_RX_DEPTH
) (
  input wire logic                            clk_i,
  input wire logic                            rst_i,
  input wire utsris_pkg::utsris_wb_req_s      wb_req_i,
  input wire logic                            wb_ack_o,
  input wire logic [utsris_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic                            rx_push_i,
  input wire logic [$clog2(RX_DEPTH+1)-1:0]   rx_level_i,
  input wire logic                            tx_pin_o,
  input wire logic                            tx_pin_oe_o,
  input wire logic                            tx_irq_o,
  input wire logic                            rx_irq_o
);
  logic       take;
  logic       cfgw;
  logic [1:0] txsel;
  logic [1:0] rxsel;
  logic       inv;
  logic       ir;
  logic       en;
  logic [3:0] age;
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign cfgw = take && wb_req_i.we && (wb_req_i.adr == 4'h0 || wb_req_i.adr == 4'h8);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // shadow of control fields, age since last config write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {txsel, rxsel, inv, ir, en} <= '0;
      age <= 4'h0;
    end else begin
      age <= cfgw ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
      if (take && wb_req_i.we && wb_req_i.adr == 4'h0 && wb_req_i.sel[1]) begin
        {txsel, inv, en} <= {wb_req_i.dat[15], wb_req_i.dat[13], wb_req_i.dat[14], wb_req_i.dat[10]};
      end
      if (take && wb_req_i.we && wb_req_i.adr == 4'h0 && wb_req_i.sel[0]) begin
        rxsel <= wb_req_i.dat[7:6];
      end
      if (take && wb_req_i.we && wb_req_i.adr == 4'h8 && wb_req_i.sel[0]) begin
        ir <= wb_req_i.dat[0];
      end
    end
  end
  // ==========================================================================
  // bus answer
  chk_ack_answer: assert property (take |=> wb_ack_o) else $error("no ack after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  chk_unmapped_zero: assert property (take && !wb_req_i.we && wb_req_i.adr != 4'h0
    && wb_req_i.adr != 4'h4 && wb_req_i.adr != 4'h8 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ctl_spare_zero: assert property (take && !wb_req_i.we && wb_req_i.adr == 4'h0
    |=> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[12] && wb_dat_o[5:0] == 6'h0)
    else $error("unused status bits set");
  // ==========================================================================
  // pin ownership and idle level
  chk_oe_follows: assert property (tx_pin_oe_o == $past(en))
    else $error("pin enable not following transmit enable");
  chk_idle_level: assert property (!tx_pin_oe_o && age > 4'h3 |-> tx_pin_o == (ir ? inv : !inv))
    else $error("wrong idle level");
  // ==========================================================================
  // transmit interrupt modes
  chk_tx_quiet_off: assert property (!en && age > 4'h1 |-> !tx_irq_o)
    else $error("transmit interrupt while disabled");
  chk_tx_done_idle: assert property (tx_irq_o && txsel == 2'h1 && !ir
    |-> $past(tx_pin_o, 2) == !inv && $past(tx_pin_o) == !inv)
    else $error("done interrupt while shifting");
  // ==========================================================================
  // receive interrupt modes
  chk_rx_any_push: assert property (rx_push_i && !rxsel[1] |=> rx_irq_o)
    else $error("missed receive interrupt");
  chk_rx_three: assert property (rx_push_i && rxsel == 2'h2
    |=> rx_irq_o == ($past(rx_level_i) == 3'h3)) else $error("three level wrong");
  chk_rx_four: assert property (rx_push_i && rxsel == 2'h3
    |=> rx_irq_o == ($past(rx_level_i) == 3'h4)) else $error("full level wrong");
  chk_rx_no_push: assert property (!rx_push_i |=> !rx_irq_o)
    else $error("receive interrupt without transfer");
endmodule
bind utsris_top utsris_props #(.CLKS_PER_BIT(CLKS_PER_BIT), .TX_DEPTH(TX_DEPTH),
  .RX_DEPTH(RX_DEPTH)) utsris_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_push_i(rx_push_i), .rx_level_i(rx_level_i),
  .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// file: tb/utsris_rx_node.sv
// partner: remote serial node that decodes frames on the transmit line
`timescale 1ns/1ps
`default_nettype none
module utsris_rx_node #(
  parameter int CPB = 4
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  output logic      [7:0] char_o,
  output int              zeros_o,
  output int              frames_o
);
  int z;
  // start edge, then mid-bit samples, lsb first
  initial begin
    char_o = 8'h00;
    zeros_o = 0;
    frames_o = 0;
    forever begin
      @(negedge line_i);
      repeat (CPB / 2) @(posedge clk_i);
      z = 1;
      for (int i = 0; i < 8; i++) begin
        repeat (CPB) @(posedge clk_i);
        char_o[i] = line_i;
        z += (line_i == 1'b0);
      end
      repeat (CPB) @(posedge clk_i);
      // a break holds the line low past the data bits
      while (line_i == 1'b0) begin
        z++;
        repeat (CPB) @(posedge clk_i);
      end
      zeros_o = z;
      frames_o++;
    end
  end
endmodule
`default_nettype wire

// file: tb/utsris_top_tb.sv
// testbench: register-level tests of the transmit control block
`timescale 1ns/1ps
`default_nettype none
module utsris_top_tb;
  localparam int CPB = 4;
  localparam int NW [4] = '{3, 2, 6, 1};
  localparam int NP [4] = '{3, 1, 2, 1};
  // interrupt mode per pass; the reserved code 11 is never written
  localparam logic [1:0] MD [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic                       clk_i;
  logic                       rst_i;
  utsris_pkg::utsris_wb_req_s wb_req;
  logic                       wb_ack;
  logic [31:0]                wb_dat;
  logic                       rx_push;
  logic [2:0]                 rx_level;
  logic                       tx_pin;
  logic                       tx_oe;
  logic                       tx_irq;
  logic                       rx_irq;
  logic                       line;
  logic [7:0]                 rx_char;
  logic [31:0]                q;
  int                         rx_zeros;
  int                         rx_frames;
  int                         irq_cnt;
  int                         base_i;
  int                         base_f;
  int                         failures;
  int                         total_checks;
  utsris_top #(.CLKS_PER_BIT(CPB)) utsris_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .rx_push_i(rx_push),
    .rx_level_i(rx_level), .tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe), .tx_irq_o(tx_irq),
    .rx_irq_o(rx_irq));
  // port logic holds the line high while the block lets go
  assign line = tx_oe ? tx_pin : 1'b1;
  utsris_rx_node #(.CPB(CPB)) utsris_rx_node_i (.clk_i(clk_i), .line_i(line),
    .char_o(rx_char), .zeros_o(rx_zeros), .frames_o(rx_frames));
  // ==========================================================================
  // clock, interrupt pulse counter, watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  // tests need under a thousand cycles, allow far more
  initial begin
    #(8 * 40000);
    failures++;
    end_of_test();
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] ctl(input logic [1:0] s);
    return {16'h0, s[1], 1'b0, s[0], 13'h0400};
  endfunction
  function automatic logic [7:0] dch(input int i);
    return 8'h5a + 8'h33 * i[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack, then one idle cycle
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h3, dat: d};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 20);
    if (wb_ack !== 1'b1) failures++;
    q = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask
  // poll status until the shifter and buffer are empty
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(4'h0, 1'b0, 32'h0);
      n++;
    end while (q[8] !== 1'b1 && n < 300);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic push(input logic [2:0] lv, input logic exp);
    rx_push <= 1'b1;
    rx_level <= lv;
    @(posedge clk_i);
    rx_push <= 1'b0;
    @(posedge clk_i);
    check({31'h0, rx_irq}, {31'h0, exp});
  endtask
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    irq_cnt = 0;
    rst_i = 1'b1;
    wb_req = '0;
    rx_push = 1'b0;
    rx_level = 3'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset value, unmapped place
    xfer(4'h0, 1'b0, 32'h0);
    check(q, 32'h0100);
    xfer(4'hc, 1'b1, 32'hffff);
    xfer(4'hc, 1'b0, 32'h0);
    check(q, 32'h0);
    // idle level for every polarity and encoding choice
    for (int k = 0; k < 4; k++) begin
      xfer(4'h8, 1'b1, {31'h0, k[1]});
      xfer(4'h0, 1'b1, {17'h0, k[0], 14'h0});
      repeat (4) @(posedge clk_i);
      check({31'h0, tx_pin}, {31'h0, k[1] ? k[0] : ~k[0]});
    end
    xfer(4'h8, 1'b1, 32'h0);
    // each transmit interrupt mode, buffer filled until refused in the third pass only
    for (int m = 0; m < 4; m++) begin
      xfer(4'h0, 1'b1, ctl(MD[m]));
      check({31'h0, tx_oe}, 32'h1);
      base_i = irq_cnt;
      base_f = rx_frames;
      for (int i = 0; i < NW[m]; i++) begin
        if (i == 5) begin
          xfer(4'h0, 1'b0, 32'h0);
          check(q, ctl(2'h2) | 32'h0200);
        end
        xfer(4'h4, 1'b1, {24'h0, dch(i)});
      end
      wait_idle();
      check(q, ctl(MD[m]) | 32'h0100);
      check(irq_cnt - base_i, NP[m]);
      check(rx_frames - base_f, (NW[m] > 5) ? 5 : NW[m]);
      check({24'h0, rx_char}, {24'h0, dch((NW[m] > 5) ? 4 : NW[m] - 1)});
    end
    // break frame and self-clearing request
    xfer(4'h0, 1'b1, ctl(2'h0) | 32'h0800);
    xfer(4'h4, 1'b1, 32'h0);
    wait_idle();
    xfer(4'h0, 1'b0, 32'h0);
    check(rx_zeros, 13);
    check(q, ctl(2'h0) | 32'h0100);
    // receive interrupt thresholds for every mode and level
    for (int s = 0; s < 4; s++) begin
      xfer(4'h0, 1'b1, {24'h0, s[1:0], 6'h0});
      for (int lv = 1; lv < 5; lv++) begin
        push(lv[2:0], s < 2 || lv == s + 1);
      end
    end
    // abort with characters queued
    xfer(4'h0, 1'b1, ctl(2'h0));
    for (int i = 0; i < 3; i++) begin
      xfer(4'h4, 1'b1, 32'h00a5);
    end
    xfer(4'h0, 1'b1, 32'h0);
    check({31'h0, tx_oe}, 32'h0);
    xfer(4'h0, 1'b0, 32'h0);
    check(q, 32'h0100);
    xfer(4'h4, 1'b0, 32'h0);
    check(q, 32'h0);
    check({31'h0, tx_pin}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
